// ---- hw/cpd_pkg.sv ----
`default_nettype none
package cpd_pkg;
  // Sizes
  localparam int CPD_UNITS = 8;
  localparam int CPD_CNT_W = 16;
  localparam int CPD_DB_W = 8;
  localparam int CPD_ADDR_W = 12;
  localparam int CPD_INT_W = 3 * CPD_UNITS + 1;

  // Per unit block: unit index in paddr[7:5], register in paddr[4:0]
  localparam logic [4:0] CPD_OFF_CTRL = 5'h00;
  localparam logic [4:0] CPD_OFF_PERIOD = 5'h04;
  localparam logic [4:0] CPD_OFF_COMPARE = 5'h08;
  localparam logic [4:0] CPD_OFF_DEADBAND = 5'h0C;
  localparam logic [4:0] CPD_OFF_COUNT = 5'h10;
  localparam logic [4:0] CPD_OFF_CAPTURE = 5'h14;
  localparam logic [3:0] CPD_UNIT_PAGE = 4'h0;

  // Global registers
  localparam logic [11:0] CPD_ADDR_INT_STAT = 12'h100;
  localparam logic [11:0] CPD_ADDR_INT_MASK = 12'h104;
  localparam logic [11:0] CPD_ADDR_CMD = 12'h108;
  localparam logic [11:0] CPD_ADDR_KILL = 12'h10C;

  // Control register fields
  localparam int CPD_CTRL_EN = 0;
  localparam int CPD_CTRL_ONESHOT = 1;
  localparam int CPD_CTRL_START = 2;
  localparam int CPD_CTRL_SWCAP = 3;
  localparam int CPD_CTRL_SAFE_T = 4;
  localparam int CPD_CTRL_SAFE_C = 5;
  localparam int CPD_CTRL_RUN = 8;

  // Command register fields
  localparam int CPD_CMD_START_LSB = 0;
  localparam int CPD_CMD_CAP_LSB = 8;

  // Kill register fields
  localparam int CPD_KILL_LATCH = 0;
  localparam int CPD_KILL_CLR = 1;
  localparam int CPD_KILL_STATE = 2;

  // Interrupt status layout
  localparam int CPD_INT_TC_LSB = 0;
  localparam int CPD_INT_MATCH_LSB = 8;
  localparam int CPD_INT_CAP_LSB = 16;
  localparam int CPD_INT_KILL = 24;

  // Reset values and step constants
  localparam logic [15:0] CPD_PERIOD_RST = 16'hFFFF;
  localparam logic [15:0] CPD_COMPARE_RST = 16'h8000;
  localparam logic [7:0] CPD_DEADBAND_RST = 8'h00;
  localparam logic [15:0] CPD_CNT_ONE = 16'h0001;
  localparam logic [7:0] CPD_DB_ONE = 8'h01;

  typedef enum logic [1:0] {
    CPD_IDLE = 2'b01,
    CPD_RUN = 2'b10
  } cpd_run_e;

  typedef struct packed {
    cpd_run_e run;
    logic [15:0] cnt;
    logic [15:0] cap;
    logic raw;
    logic tr;
    logic cp;
    logic [7:0] dt;
    logic pend;
    logic cap_prev;
    logic ev_tc;
    logic ev_match;
    logic ev_cap;
  } cpd_unit_s;
endpackage
`default_nettype wire

// ---- hw/cpd_chan_if.sv ----
`default_nettype none
interface cpd_chan_if;
  logic enable;
  logic oneshot;
  logic start;
  logic sw_cap;
  logic cap_in;
  logic [15:0] period;
  logic [15:0] compare;
  logic [7:0] deadband;
  logic [15:0] count;
  logic [15:0] capture;
  logic running;
  logic ev_tc;
  logic ev_match;
  logic ev_cap;
  logic out_true;
  logic out_comp;

  modport ctl(
    output enable, oneshot, start, sw_cap, cap_in, period, compare, deadband,
    input count, capture, running, ev_tc, ev_match, ev_cap, out_true, out_comp
  );
  modport unit(
    input enable, oneshot, start, sw_cap, cap_in, period, compare, deadband,
    output count, capture, running, ev_tc, ev_match, ev_cap, out_true, out_comp
  );
endinterface
`default_nettype wire

// ---- hw/cpd_unit.sv ----
`default_nettype none
module cpd_unit (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Control and status
  cpd_chan_if.unit bus
);
  localparam cpd_pkg::cpd_unit_s UNIT_RST = '{
    run: cpd_pkg::CPD_IDLE, cnt: '0, cap: '0, raw: 1'b0, tr: 1'b0, cp: 1'b0,
    dt: '0, pend: 1'b1, cap_prev: 1'b0, ev_tc: 1'b0, ev_match: 1'b0, ev_cap: 1'b0};

  cpd_pkg::cpd_unit_s st_ff;
  cpd_pkg::cpd_unit_s nxt_st;
  logic cap_edge;
  logic raw_now;

  always_comb begin
    nxt_st = st_ff;
    nxt_st.ev_tc = 1'b0;
    nxt_st.ev_match = 1'b0;
    nxt_st.ev_cap = 1'b0;
    nxt_st.cap_prev = bus.cap_in;
    cap_edge = (bus.cap_in & ~st_ff.cap_prev) | bus.sw_cap;
    if (cap_edge) begin
      nxt_st.cap = st_ff.cnt;
      nxt_st.ev_cap = 1'b1;
    end
    case (st_ff.run)
      cpd_pkg::CPD_IDLE: begin
        if (bus.enable && bus.start) begin
          nxt_st.run = cpd_pkg::CPD_RUN;
          nxt_st.cnt = '0;
        end
      end
      cpd_pkg::CPD_RUN: begin
        if (!bus.enable) begin
          nxt_st.run = cpd_pkg::CPD_IDLE;
        end else begin
          if (st_ff.cnt == bus.compare) begin
            nxt_st.ev_match = 1'b1;
          end
          if (st_ff.cnt == bus.period) begin
            nxt_st.ev_tc = 1'b1;
            if (bus.oneshot) begin
              nxt_st.run = cpd_pkg::CPD_IDLE;
            end else begin
              nxt_st.cnt = '0;
            end
          end else begin
            nxt_st.cnt = st_ff.cnt + cpd_pkg::CPD_CNT_ONE;
          end
        end
      end
      default: nxt_st.run = cpd_pkg::CPD_IDLE;
    endcase
    // Duty cycle: high while below compare
    raw_now = (st_ff.run == cpd_pkg::CPD_RUN) && (st_ff.cnt < bus.compare);
    nxt_st.raw = raw_now;
    // Break before make: both off, wait dead band, then turn one on
    if (raw_now != st_ff.raw) begin
      nxt_st.tr = 1'b0;
      nxt_st.cp = 1'b0;
      nxt_st.dt = bus.deadband;
      nxt_st.pend = 1'b1;
    end else if (st_ff.pend) begin
      if (st_ff.dt != '0) begin
        nxt_st.dt = st_ff.dt - cpd_pkg::CPD_DB_ONE;
      end else begin
        nxt_st.tr = st_ff.raw;
        nxt_st.cp = ~st_ff.raw;
        nxt_st.pend = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= UNIT_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign bus.count = st_ff.cnt;
  assign bus.capture = st_ff.cap;
  assign bus.running = (st_ff.run == cpd_pkg::CPD_RUN);
  assign bus.ev_tc = st_ff.ev_tc;
  assign bus.ev_match = st_ff.ev_match;
  assign bus.ev_cap = st_ff.ev_cap;
  assign bus.out_true = st_ff.tr;
  assign bus.out_comp = st_ff.cp;
endmodule // cpd_unit
`default_nettype wire

// ---- hw/cpd_top.sv ----
// Contract
// - Each unit has a 16-bit counter with a software set period.
// - A capture event, pin or software, copies the count to a readable register.
// - At count equal period, stop in one-shot mode or reload in continuous mode.
// - Compare value against count produces match signals setting PWM duty cycle.
// - True and complementary outputs with programmable dead band, never switching together; kill switches both at once to safe_t and safe_c, with no dead band.
// - Kill input forces both outputs to a safe level at once.
// - Eight identical, independently configured units.
//
// Register access over APB and the address map were left to the implementer.
`default_nettype none
module cpd_top (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Capture and kill pins
  input wire logic [7:0] cap_in,
  input wire logic kill_in,
  // PWM pins
  output logic [7:0] pwm_true,
  output logic [7:0] pwm_comp,
  // Interrupt
  output logic irq
);
  typedef struct packed {
    logic [7:0] en;
    logic [7:0] oneshot;
    logic [7:0] safe_t;
    logic [7:0] safe_c;
    logic [7:0] start;
    logic [7:0] swcap;
    logic [7:0][15:0] period;
    logic [7:0][15:0] compare;
    logic [7:0][7:0] deadband;
    logic [24:0] int_stat;
    logic [24:0] int_mask;
    logic kill_latch_en;
    logic kill_held;
    logic kill_prev;
    logic kill_gap;
    logic [31:0] rdata;
  } cpd_regs_s;

  localparam cpd_regs_s REGS_RST = '{
    en: '0, oneshot: '0, safe_t: '0, safe_c: '0, start: '0, swcap: '0,
    period: {cpd_pkg::CPD_UNITS{cpd_pkg::CPD_PERIOD_RST}},
    compare: {cpd_pkg::CPD_UNITS{cpd_pkg::CPD_COMPARE_RST}},
    deadband: {cpd_pkg::CPD_UNITS{cpd_pkg::CPD_DEADBAND_RST}},
    int_stat: '0, int_mask: '0, kill_latch_en: 1'b0, kill_held: 1'b0,
    kill_prev: 1'b0, kill_gap: 1'b0, rdata: '0};

  cpd_regs_s st_ff;
  cpd_regs_s nxt_st;

  logic [7:0][15:0] cnt_v;
  logic [7:0][15:0] cap_v;
  logic [7:0] run_v;
  logic [7:0] tc_v;
  logic [7:0] match_v;
  logic [7:0] capev_v;
  logic [7:0] tr_v;
  logic [7:0] cm_v;

  logic setup;
  logic wr;
  logic hit;
  logic kill_act;
  logic [2:0] u_sel;
  logic [4:0] r_sel;
  logic [24:0] int_set;
  logic [24:0] int_clr;

  function automatic logic [2:0] unit_of(input logic [11:0] a);
    unit_of = a[7:5];
  endfunction

  function automatic logic [4:0] reg_of(input logic [11:0] a);
    reg_of = a[4:0];
  endfunction

  function automatic logic addr_ok(input logic [11:0] a);
    logic unit_pg;
    unit_pg = (a[11:8] == cpd_pkg::CPD_UNIT_PAGE) && (a[4:0] <= cpd_pkg::CPD_OFF_CAPTURE)
      && (a[1:0] == 2'b00);
    addr_ok = unit_pg || (a == cpd_pkg::CPD_ADDR_INT_STAT) || (a == cpd_pkg::CPD_ADDR_INT_MASK)
      || (a == cpd_pkg::CPD_ADDR_CMD) || (a == cpd_pkg::CPD_ADDR_KILL);
  endfunction

  function automatic logic is_unit(input logic [11:0] a);
    is_unit = (a[11:8] == cpd_pkg::CPD_UNIT_PAGE);
  endfunction

  // Eight independent units
  for (genvar g = 0; g < cpd_pkg::CPD_UNITS; g++) begin : g_unit
    cpd_chan_if ch_if ();

    assign ch_if.enable = st_ff.en[g];
    assign ch_if.oneshot = st_ff.oneshot[g];
    assign ch_if.start = st_ff.start[g];
    assign ch_if.sw_cap = st_ff.swcap[g];
    assign ch_if.cap_in = cap_in[g];
    assign ch_if.period = st_ff.period[g];
    assign ch_if.compare = st_ff.compare[g];
    assign ch_if.deadband = st_ff.deadband[g];
    assign cnt_v[g] = ch_if.count;
    assign cap_v[g] = ch_if.capture;
    assign run_v[g] = ch_if.running;
    assign tc_v[g] = ch_if.ev_tc;
    assign match_v[g] = ch_if.ev_match;
    assign capev_v[g] = ch_if.ev_cap;
    assign tr_v[g] = ch_if.out_true;
    assign cm_v[g] = ch_if.out_comp;

    cpd_unit u_unit (
      .pclk(pclk),
      .presetn(presetn),
      .bus(ch_if.unit)
    );
  end

  // Kill acts combinationally so no clock edge stands between fault and switch-off
  assign kill_act = kill_in | st_ff.kill_held;
  // One both-low cycle after release, so no leg crosses from safe level to drive
  assign pwm_true = kill_act ? st_ff.safe_t : (st_ff.kill_gap ? 8'h00 : tr_v);
  assign pwm_comp = kill_act ? st_ff.safe_c : (st_ff.kill_gap ? 8'h00 : cm_v);
  assign irq = |(st_ff.int_stat & st_ff.int_mask);

  // Zero wait states; read data sampled in the setup cycle
  assign pready = 1'b1;
  assign prdata = st_ff.rdata;
  assign pslverr = psel & penable & ~addr_ok(paddr);

  assign setup = psel & ~penable;
  assign wr = psel & penable & pwrite & addr_ok(paddr);
  assign u_sel = unit_of(paddr);
  assign r_sel = reg_of(paddr);
  assign hit = is_unit(paddr);

  always_comb begin
    nxt_st = st_ff;
    nxt_st.start = '0;
    nxt_st.swcap = '0;
    nxt_st.kill_prev = kill_in;
    nxt_st.kill_gap = kill_act;
    int_set = {kill_in & ~st_ff.kill_prev, capev_v, match_v, tc_v};
    int_clr = '0;

    // Register writes
    if (wr && hit) begin
      case (r_sel)
        cpd_pkg::CPD_OFF_CTRL: begin
          nxt_st.en[u_sel] = pwdata[cpd_pkg::CPD_CTRL_EN];
          nxt_st.oneshot[u_sel] = pwdata[cpd_pkg::CPD_CTRL_ONESHOT];
          nxt_st.start[u_sel] = pwdata[cpd_pkg::CPD_CTRL_START];
          nxt_st.swcap[u_sel] = pwdata[cpd_pkg::CPD_CTRL_SWCAP];
          nxt_st.safe_t[u_sel] = pwdata[cpd_pkg::CPD_CTRL_SAFE_T];
          nxt_st.safe_c[u_sel] = pwdata[cpd_pkg::CPD_CTRL_SAFE_C];
        end
        cpd_pkg::CPD_OFF_PERIOD: nxt_st.period[u_sel] = pwdata[15:0];
        cpd_pkg::CPD_OFF_COMPARE: nxt_st.compare[u_sel] = pwdata[15:0];
        cpd_pkg::CPD_OFF_DEADBAND: nxt_st.deadband[u_sel] = pwdata[7:0];
        default: nxt_st.en = st_ff.en;
      endcase
    end else if (wr) begin
      case (paddr)
        cpd_pkg::CPD_ADDR_INT_STAT: int_clr = pwdata[24:0];
        cpd_pkg::CPD_ADDR_INT_MASK: nxt_st.int_mask = pwdata[24:0];
        cpd_pkg::CPD_ADDR_CMD: begin
          nxt_st.start = pwdata[cpd_pkg::CPD_CMD_START_LSB +: 8];
          nxt_st.swcap = pwdata[cpd_pkg::CPD_CMD_CAP_LSB +: 8];
        end
        cpd_pkg::CPD_ADDR_KILL: begin
          nxt_st.kill_latch_en = pwdata[cpd_pkg::CPD_KILL_LATCH];
          if (pwdata[cpd_pkg::CPD_KILL_CLR]) begin
            nxt_st.kill_held = 1'b0;
          end
        end
        default: nxt_st.int_mask = st_ff.int_mask;
      endcase
    end

    // Held kill re-arms if the pin is still asserted during the clear
    if (kill_in && st_ff.kill_latch_en) begin
      nxt_st.kill_held = 1'b1;
    end

    // Set wins over a simultaneous write-one clear
    nxt_st.int_stat = (st_ff.int_stat & ~int_clr) | int_set;

    // Read data captured in setup, stable through the access cycle
    if (setup) begin
      nxt_st.rdata = '0;
      if (!pwrite && hit) begin
        case (r_sel)
          cpd_pkg::CPD_OFF_CTRL: begin
            nxt_st.rdata[cpd_pkg::CPD_CTRL_EN] = st_ff.en[u_sel];
            nxt_st.rdata[cpd_pkg::CPD_CTRL_ONESHOT] = st_ff.oneshot[u_sel];
            nxt_st.rdata[cpd_pkg::CPD_CTRL_SAFE_T] = st_ff.safe_t[u_sel];
            nxt_st.rdata[cpd_pkg::CPD_CTRL_SAFE_C] = st_ff.safe_c[u_sel];
            nxt_st.rdata[cpd_pkg::CPD_CTRL_RUN] = run_v[u_sel];
          end
          cpd_pkg::CPD_OFF_PERIOD: nxt_st.rdata[15:0] = st_ff.period[u_sel];
          cpd_pkg::CPD_OFF_COMPARE: nxt_st.rdata[15:0] = st_ff.compare[u_sel];
          cpd_pkg::CPD_OFF_DEADBAND: nxt_st.rdata[7:0] = st_ff.deadband[u_sel];
          cpd_pkg::CPD_OFF_COUNT: nxt_st.rdata[15:0] = cnt_v[u_sel];
          cpd_pkg::CPD_OFF_CAPTURE: nxt_st.rdata[15:0] = cap_v[u_sel];
          default: nxt_st.rdata = '0;
        endcase
      end else if (!pwrite) begin
        case (paddr)
          cpd_pkg::CPD_ADDR_INT_STAT: nxt_st.rdata[24:0] = st_ff.int_stat;
          cpd_pkg::CPD_ADDR_INT_MASK: nxt_st.rdata[24:0] = st_ff.int_mask;
          cpd_pkg::CPD_ADDR_KILL: begin
            nxt_st.rdata[cpd_pkg::CPD_KILL_LATCH] = st_ff.kill_latch_en;
            nxt_st.rdata[cpd_pkg::CPD_KILL_STATE] = kill_act;
          end
          default: nxt_st.rdata = '0;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= REGS_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end
endmodule // cpd_top
`default_nettype wire

// ---- verification/cpd_top_checker.sv ----
`default_nettype none
module cpd_top_checker (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  // Pins
  input wire logic [7:0] cap_in,
  input wire logic kill_in,
  input wire logic [7:0] pwm_true,
  input wire logic [7:0] pwm_comp,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_mask_off;
    s_acc ##0 (pwrite && paddr == cpd_pkg::CPD_ADDR_INT_MASK && pwdata == 32'h0000_0000);
  endsequence
  sequence s_calm;
    !kill_in ##1 !kill_in;
  endsequence
  a_ready_now: assert property (s_acc |-> pready)
    else $error("pready low in access phase");
  a_err_idle: assert property (!(psel && penable) |-> !pslverr)
    else $error("pslverr outside access phase");
  a_err_misalign: assert property (s_acc ##0 paddr[1:0] != 2'b00 |-> pslverr)
    else $error("misaligned access without pslverr");
  a_err_rdzero: assert property (s_acc ##0 (!pwrite && pslverr) |-> prdata == 32'h0000_0000)
    else $error("refused read returned data");
  a_no_overlap: assert property (!kill_in |-> (pwm_true & pwm_comp) == 8'h00)
    else $error("true and complement high together");
  a_dead_gap: assert property (s_calm |-> (((pwm_true & ~$past(pwm_true)) |
    (pwm_comp & ~$past(pwm_comp))) & ($past(pwm_true) | $past(pwm_comp))) == 8'h00)
    else $error("output rose without both-low gap");
  a_kill_hold: assert property (kill_in && $past(kill_in) && !$past(psel) |->
    $stable(pwm_true) && $stable(pwm_comp))
    else $error("outputs moved during kill");
  a_mask_clear: assert property (s_mask_off |=> !irq [*2])
    else $error("irq high with all masks cleared");
endmodule // cpd_top_checker
bind cpd_top cpd_top_checker cpd_top_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
  .prdata(prdata), .pslverr(pslverr), .cap_in(cap_in), .kill_in(kill_in),
  .pwm_true(pwm_true), .pwm_comp(pwm_comp), .irq(irq));
`default_nettype wire

// ---- verification/cpd_power_stage.sv ----
`default_nettype none
module cpd_power_stage (
  // Clock
  input wire logic pclk,
  // Gate drives
  input wire logic [7:0] gate_hi,
  input wire logic [7:0] gate_lo,
  // Fault injection
  input wire logic trip,
  // Sense
  output logic overcurrent,
  output var logic [15:0] shoot_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  logic short_seen;
  // Both switches of one leg on shorts the supply
  // Sense lags one clock, which also breaks the loop through kill
  initial short_seen = 1'b0;
  assign overcurrent = trip || short_seen;
  initial shoot_cnt = 16'h0000;
  always @(posedge pclk) begin
    short_seen <= (gate_hi & gate_lo) != 8'h00;
    if (!trip && (gate_hi & gate_lo) != 8'h00) begin
      shoot_cnt <= shoot_cnt + 16'h0001;
    end
  end
endmodule // cpd_power_stage
`default_nettype wire

// ---- verification/cpd_top_tb.sv ----
`default_nettype none
module cpd_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [31:0] data; logic [31:0] mask; logic err;} cpd_exp_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, kill_in, irq, trip;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic [7:0] cap_in, pwm_true, pwm_comp;
  logic [15:0] shoot_cnt;
  cpd_exp_s exp_q[$];
  cpd_exp_s e;
  int mismatches, check_count, cycles, seed, span, hi, gap, hi0, gap0;

  cpd_top cpd_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .cap_in(cap_in), .kill_in(kill_in), .pwm_true(pwm_true),
    .pwm_comp(pwm_comp), .irq(irq));
  cpd_power_stage cpd_power_stage_i (.pclk(pclk), .gate_hi(pwm_true), .gate_lo(pwm_comp),
    .trip(trip), .overcurrent(kill_in), .shoot_cnt(shoot_cnt));

  always #5 pclk = ~pclk;

  task automatic check(string what, logic [31:0] expv, logic [31:0] got);
    check_count++;
    if (got !== expv) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", what, expv, got);
    end
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // Read watcher and hang guard
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1 && pwrite === 1'b0 &&
        exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check("read data", e.data & e.mask, prdata & e.mask);
      check("slave error", 32'(e.err), 32'(pslverr));
    end
    if (cycles > 20000) begin
      mismatches++;
      print_verdict();
    end
  end

  function automatic logic [11:0] ua(int u, logic [4:0] off);
    return {cpd_pkg::CPD_UNIT_PAGE, u[2:0], off};
  endfunction

  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(logic [11:0] a, logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rd(logic [11:0] a, logic [31:0] x, logic [31:0] m = 32'hffff_ffff,
                    logic err = 1'b0);
    exp_q.push_back('{x, m, err});
    apb(1'b0, a, 32'h0000_0000);
  endtask

  task automatic wait_irq(logic v);
    for (int i = 0; i < 200 && irq !== v; i++) @(posedge pclk);
    check("irq", 32'(v), 32'(irq));
  endtask

  // One full cycle of unit u, from rise to rise of the true output
  task automatic measure(int u);
    logic prev;
    span = 0;
    hi = 0;
    gap = 0;
    repeat (2) begin
      wait (pwm_true[u] === 1'b0);
      wait (pwm_true[u] === 1'b1);
    end
    prev = 1'b1;
    @(negedge pclk);
    while (!(pwm_true[u] === 1'b1 && !prev)) begin
      span++;
      hi += int'(pwm_true[u] === 1'b1);
      gap += int'(pwm_true[u] !== 1'b1 && pwm_comp[u] !== 1'b1);
      prev = pwm_true[u];
      @(negedge pclk);
    end
  endtask

  initial begin
    seed = 32'hb654;
    {pclk, presetn, psel, penable, pwrite, trip} = 6'h00;
    {paddr, pwdata, cap_in} = 52'h0_0000_0000_0000;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    for (int u = 0; u < 8; u++) begin
      rd(ua(u, cpd_pkg::CPD_OFF_PERIOD), 32'h0000_ffff);
      rd(ua(u, cpd_pkg::CPD_OFF_COMPARE), 32'h0000_8000);
      rd(ua(u, cpd_pkg::CPD_OFF_COUNT), 32'h0000_0000);
    end
    rd(12'h1f0, 32'h0000_0000, 32'hffff_ffff, 1'b1);
    rd(12'h006, 32'h0000_0000, 32'hffff_ffff, 1'b1);
    wr(ua(3, cpd_pkg::CPD_OFF_COUNT), 32'h0000_1234);
    rd(ua(3, cpd_pkg::CPD_OFF_COUNT), 32'h0000_0000);
    for (int u = 0; u < 8; u++) begin
      r = $random(seed);
      wr(ua(u, cpd_pkg::CPD_OFF_PERIOD), {16'h0000, r[15:0]});
      wr(ua(u, cpd_pkg::CPD_OFF_COMPARE), {16'h0000, r[31:16]});
      rd(ua(u, cpd_pkg::CPD_OFF_PERIOD), {16'h0000, r[15:0]});
      rd(ua(u, cpd_pkg::CPD_OFF_COMPARE), {16'h0000, r[31:16]});
    end
    // One-shot run on unit 2, terminal count raises the interrupt
    wr(ua(2, cpd_pkg::CPD_OFF_PERIOD), 32'h0000_0005);
    wr(cpd_pkg::CPD_ADDR_INT_MASK, 32'h0000_0004);
    wr(ua(2, cpd_pkg::CPD_OFF_CTRL), 32'h0000_0003);
    wr(cpd_pkg::CPD_ADDR_CMD, 32'h0000_0004);
    wait_irq(1'b1);
    rd(ua(2, cpd_pkg::CPD_OFF_COUNT), 32'h0000_0005);
    rd(ua(2, cpd_pkg::CPD_OFF_CTRL), 32'h0000_0003, 32'h0000_0103);
    rd(cpd_pkg::CPD_ADDR_INT_STAT, 32'h0000_0004, 32'h0000_0004);
    wr(cpd_pkg::CPD_ADDR_INT_MASK, 32'h0000_0000);
    wait_irq(1'b0);
    wr(cpd_pkg::CPD_ADDR_INT_MASK, 32'h0000_0004);
    wait_irq(1'b1);
    wr(cpd_pkg::CPD_ADDR_INT_STAT, 32'h0000_0004);
    wait_irq(1'b0);
    // Pin capture on halted unit 2, software capture on unit 3
    cap_in <= 8'h04;
    repeat (4) @(posedge pclk);
    rd(ua(2, cpd_pkg::CPD_OFF_CAPTURE), 32'h0000_0005);
    cap_in <= 8'h00;
    wr(cpd_pkg::CPD_ADDR_CMD, 32'h0000_0800);
    repeat (4) @(posedge pclk);
    rd(cpd_pkg::CPD_ADDR_INT_STAT, 32'h000c_0000, 32'h000c_0000);
    // Continuous PWM on unit 0
    wr(ua(0, cpd_pkg::CPD_OFF_PERIOD), 32'h0000_000f);
    wr(ua(0, cpd_pkg::CPD_OFF_COMPARE), 32'h0000_0006);
    wr(ua(0, cpd_pkg::CPD_OFF_DEADBAND), 32'h0000_0000);
    wr(ua(0, cpd_pkg::CPD_OFF_CTRL), 32'h0000_0001);
    wr(cpd_pkg::CPD_ADDR_CMD, 32'h0000_0001);
    measure(0);
    check("pwm period", 32'h0000_0010, 32'(span));
    hi0 = hi;
    wr(ua(0, cpd_pkg::CPD_OFF_COMPARE), 32'h0000_000c);
    measure(0);
    check("duty step", 32'h0000_0006, 32'(hi - hi0));
    gap0 = gap;
    wr(ua(0, cpd_pkg::CPD_OFF_DEADBAND), 32'h0000_0002);
    measure(0);
    check("dead band step", 32'h0000_0004, 32'(gap - gap0));
    check("shoot through", 32'h0000_0000, 32'(shoot_cnt));
    // Overcurrent trip while true is high; safe level true low, complement high
    wr(ua(0, cpd_pkg::CPD_OFF_CTRL), 32'h0000_0021);
    wait (pwm_true[0] === 1'b0);
    wait (pwm_true[0] === 1'b1);
    @(posedge pclk);
    trip <= 1'b1;
    #1;
    check("kill true", 32'h0000_0000, 32'(pwm_true[0]));
    check("kill comp", 32'h0000_0001, 32'(pwm_comp[0]));
    rd(cpd_pkg::CPD_ADDR_KILL, 32'h0000_0004, 32'h0000_0004);
    trip <= 1'b0;
    wr(cpd_pkg::CPD_ADDR_KILL, 32'h0000_0002);
    measure(0);
    check("resume period", 32'h0000_0010, 32'(span));
    // Latched kill outlives the pin until software clears it
    wr(cpd_pkg::CPD_ADDR_KILL, 32'h0000_0001);
    trip <= 1'b1;
    @(posedge pclk);
    trip <= 1'b0;
    rd(cpd_pkg::CPD_ADDR_KILL, 32'h0000_0005, 32'h0000_0005);
    check("held kill comp", 32'h0000_0001, 32'(pwm_comp[0]));
    wr(cpd_pkg::CPD_ADDR_KILL, 32'h0000_0003);
    rd(cpd_pkg::CPD_ADDR_KILL, 32'h0000_0001, 32'h0000_0005);
    rd(cpd_pkg::CPD_ADDR_INT_STAT, 32'h0100_0100, 32'h0100_0100);
    print_verdict();
  end
endmodule // cpd_top_tb
`default_nettype wire
